// ==== hdl/sps_port.sv ====
// Byte-wide serial port, master or slave, with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "sps_params.svh"
module sps_port
	import sps_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Low-power control
	input  wire logic        stop_req,
	input  wire logic        deep_stop_wake,
	// Serial pins, each input, output and enable
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe
);
	logic       rst_m_q, rst_n_q;
	logic [7:0] ctrl1_q, ctrl2_q, rate_q;
	logic [7:0] txbuf_q, rxbuf_q, shift_q;
	logic       txempty_q, rxfull_q, fault_q;
	logic       wr_q, rd_ph_q;
	logic [11:0] a_q;
	sps_state_t st_q;
	logic [3:0] cnt_q;
	logic       half_q, sck_q;
	logic [2:0] pre_q;
	logic [7:0] div_q;
	logic       tick;
	logic       sck_d1_q, ss_d1_q;
	logic       run;
	sps_cfg_t   cfg;
	logic       acc, wr_data, rd_data;
	logic       in_bit, out_bit, sck_lead, sck_trail;
	logic       slv_sel, lead_edge, trail_edge;
	logic       in_q;
	logic [7:0] shift_in, rx_next;

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// Configuration decode; stop makes the module inactive
	assign run = ctrl1_q[`SPS_C1_ENABLE] & ~stop_req;
	assign cfg = '{en: run, master: ctrl1_q[`SPS_C1_MASTER], idle: ctrl1_q[`SPS_C1_IDLE],
		phase: ctrl1_q[`SPS_C1_PHASE], seloe: ctrl1_q[`SPS_C1_SELOE],
		lsb: ctrl1_q[`SPS_C1_ORDER], mfen: ctrl2_q[`SPS_C2_MFEN],
		shoe: ctrl2_q[`SPS_C2_SHOE], swire: ctrl2_q[`SPS_C2_SWIRE]};

	// Bus address phase capture; zero wait states
	assign acc = hsel & hready & htrans[1];
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_q    <= 1'b0;
			rd_ph_q <= 1'b0;
			a_q     <= 12'h000;
		end else begin
			wr_q    <= acc & hwrite;
			rd_ph_q <= acc & ~hwrite;
			a_q     <= acc ? haddr : a_q;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_data   = wr_q && a_q == `SPS_OFS_DATA;
	assign rd_data   = rd_ph_q && a_q == `SPS_OFS_DATA;

	// Read mux, unmapped reads return zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_ph_q) begin
			case (a_q)
				`SPS_OFS_CTRL1:  hrdata = {24'h00_0000, ctrl1_q};
				`SPS_OFS_CTRL2:  hrdata = {24'h00_0000, ctrl2_q};
				`SPS_OFS_RATE:   hrdata = {24'h00_0000, rate_q};
				`SPS_OFS_STATUS: hrdata = {24'h00_0000, rxfull_q, 1'b0, txempty_q,
					fault_q, 4'h0};
				`SPS_OFS_DATA:   hrdata = {24'h00_0000, rxbuf_q};
				default:         hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Control registers; deep-stop wake forces reset state
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl1_q <= `SPS_CTRL1_RST;
			ctrl2_q <= `SPS_CTRL2_RST;
			rate_q  <= `SPS_RATE_RST;
		end else if (deep_stop_wake) begin
			ctrl1_q <= `SPS_CTRL1_RST;
			ctrl2_q <= `SPS_CTRL2_RST;
			rate_q  <= `SPS_RATE_RST;
		end else if (wr_q && !stop_req) begin
			if (a_q == `SPS_OFS_CTRL1) ctrl1_q <= hwdata[7:0] & 8'h5F;
			if (a_q == `SPS_OFS_CTRL2) ctrl2_q <= hwdata[7:0] & 8'h19;
			if (a_q == `SPS_OFS_RATE)  rate_q  <= hwdata[7:0] & 8'h77;
		end
	end

	// Bit-rate divider: prescale 1..8 then 2..256
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pre_q <= 3'h0;
			div_q <= 8'h00;
		end else if (!run || st_q != SPS_SHIFT || !cfg.master) begin
			pre_q <= 3'h0;
			div_q <= 8'h00;
		end else if (pre_q == rate_q[6:4]) begin
			pre_q <= 3'h0;
			div_q <= div_q + 8'h01;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end
	// Half-period tick: rate n divides by 2^(n+1), half period 2^n prescaled ticks
	assign tick = (pre_q == rate_q[6:4]) &&
		((div_q & ((8'h01 << rate_q[2:0]) - 8'h01)) == ((8'h01 << rate_q[2:0]) - 8'h01));

	// Slave clock and select sampling
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sck_d1_q <= 1'b0;
			ss_d1_q  <= 1'b1;
		end else begin
			sck_d1_q <= sck_i;
			ss_d1_q  <= ss_n_i;
		end
	end
	assign slv_sel    = run & ~cfg.master & ~ss_n_i;
	assign sck_lead   = (sck_i ^ cfg.idle) & ~(sck_d1_q ^ cfg.idle);
	assign sck_trail  = ~(sck_i ^ cfg.idle) & (sck_d1_q ^ cfg.idle);
	// Sample on first edge when phase 0, second when phase 1
	assign lead_edge  = cfg.master ? (tick & ~half_q) : (slv_sel & sck_lead);
	assign trail_edge = cfg.master ? (tick & half_q) : (slv_sel & sck_trail);

	// Shifter input pin: shared line in single-wire mode
	always_comb begin
		if (cfg.master)
			in_bit = miso_i;
		else
			in_bit = mosi_i;
		if (cfg.swire)
			in_bit = cfg.master ? mosi_i : miso_i;
	end
	assign out_bit = cfg.lsb ? shift_q[0] : shift_q[7];
	// Shifter advance with the held sample; output moves only on the shift edge
	assign shift_in = cfg.lsb ? {in_q, shift_q[7:1]} : {shift_q[6:0], in_q};
	// Phase 1 still owes the last held sample when the frame ends
	assign rx_next  = cfg.phase ? shift_in : shift_q;

	// Transfer engine, buffers and flags
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q      <= SPS_IDLE;
			shift_q   <= 8'h00;
			txbuf_q   <= 8'h00;
			rxbuf_q   <= 8'h00;
			txempty_q <= 1'b1;
			rxfull_q  <= 1'b0;
			cnt_q     <= 4'h0;
			half_q    <= 1'b0;
			sck_q     <= 1'b0;
			in_q      <= 1'b0;
		end else if (!ctrl1_q[`SPS_C1_ENABLE] || deep_stop_wake) begin
			st_q      <= SPS_IDLE;
			shift_q   <= 8'h00;
			txbuf_q   <= 8'h00;
			rxbuf_q   <= 8'h00;
			txempty_q <= 1'b1;
			rxfull_q  <= 1'b0;
			cnt_q     <= 4'h0;
			half_q    <= 1'b0;
			sck_q     <= 1'b0;
		end else if (!stop_req) begin
			if (wr_data) begin
				txbuf_q   <= hwdata[7:0];
				txempty_q <= 1'b0;
			end
			// Read of data clears full, new byte wins over the clear
			if (rd_data) rxfull_q <= 1'b0;
			case (st_q)
				SPS_IDLE: begin
					cnt_q  <= 4'h0;
					half_q <= 1'b0;
					sck_q  <= 1'b0;
					// Master starts only with a queued byte; slave loads on select
					if ((cfg.master && !txempty_q) || (!cfg.master && slv_sel)) begin
						shift_q   <= txbuf_q;
						txempty_q <= wr_data ? 1'b0 : 1'b1;
						st_q      <= SPS_SHIFT;
					end
				end
				SPS_SHIFT: begin
					if (!cfg.master && ss_n_i) begin
						st_q <= SPS_IDLE;
					end else if (lead_edge) begin
						half_q <= 1'b1;
						sck_q  <= 1'b1;
						if (cfg.phase) begin
							// Phase 1 shifts out at leading edges after the first
							if (cnt_q != 4'h0) shift_q <= shift_in;
						end else begin
							in_q <= in_bit;
						end
					end else if (trail_edge) begin
						half_q <= 1'b0;
						sck_q  <= 1'b0;
						cnt_q  <= cnt_q + 4'h1;
						// Phase 0 shifts on trailing edges so data is stable at sampling
						if (cfg.phase)
							in_q <= in_bit;
						else
							shift_q <= shift_in;
						if (cnt_q == `SPS_BITS - 4'h1) st_q <= SPS_DONE;
					end
				end
				SPS_DONE: begin
					// Phase 1 takes its last bit on the final trailing edge
					rxbuf_q  <= rx_next;
					rxfull_q <= 1'b1;
					st_q     <= SPS_IDLE;
				end
				default: st_q <= SPS_IDLE;
			endcase
		end
	end

	// Mode fault: select pulled low while master with fault input
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q)
			fault_q <= 1'b0;
		else if (!run)
			fault_q <= 1'b0;
		else if (cfg.master && cfg.mfen && !cfg.seloe && !ss_d1_q)
			fault_q <= 1'b1;
		else if (rd_ph_q && a_q == `SPS_OFS_STATUS)
			fault_q <= 1'b0;
	end

	// Pin routing; disabled releases every pin
	always_comb begin
		sck_o   = 1'b0;
		sck_oe  = 1'b0;
		mosi_o  = 1'b0;
		mosi_oe = 1'b0;
		miso_o  = 1'b0;
		miso_oe = 1'b0;
		ss_n_o  = 1'b1;
		ss_n_oe = 1'b0;
		if (run) begin
			if (cfg.master) begin
				sck_o  = sck_q ^ cfg.idle;
				sck_oe = 1'b1;
				mosi_o = out_bit;
				mosi_oe = cfg.swire ? cfg.shoe : 1'b1;
				ss_n_o  = (st_q == SPS_IDLE);
				ss_n_oe = cfg.mfen & cfg.seloe;
			end else begin
				miso_o  = out_bit;
				miso_oe = (cfg.swire ? cfg.shoe : 1'b1) & ~ss_n_i;
			end
		end
	end

	// Checks
	a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(run && cfg.master && st_q == SPS_IDLE) |-> sck_o == cfg.idle)
		else $error("clock not at idle level");
	a_release_off: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		!run |-> !(sck_oe || mosi_oe || miso_oe || ss_n_oe))
		else $error("pin driven while disabled");
	a_slave_no_sck: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(run && !cfg.master) |-> !sck_oe)
		else $error("slave drives clock");
	a_ss_gpio: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(cfg.master && !cfg.mfen) |-> !ss_n_oe)
		else $error("select pin driven");
	a_disable_clear: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		!ctrl1_q[`SPS_C1_ENABLE] |=> (txempty_q && !rxfull_q && st_q == SPS_IDLE))
		else $error("disable left state");
	a_rx_copy: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(st_q == SPS_DONE && run) |=> (rxfull_q && rxbuf_q == $past(rx_next)))
		else $error("receive byte not copied");
	a_tx_load: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(st_q == SPS_IDLE && run && cfg.master && !txempty_q)
		|=> (st_q == SPS_SHIFT && shift_q == $past(txbuf_q)))
		else $error("transmit byte not loaded");
	a_swire_pin: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(run && cfg.swire && cfg.master) |-> (!miso_oe && mosi_oe == cfg.shoe))
		else $error("shared line direction wrong");
endmodule
`default_nettype wire

// ==== hdl/sps_params.svh ====
// Register offsets, field positions, reset values and frame length of the serial port
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_OFS_CTRL1      12'h000
`define SPS_OFS_CTRL2      12'h004
`define SPS_OFS_RATE       12'h008
`define SPS_OFS_STATUS     12'h00C
`define SPS_OFS_DATA       12'h010
`define SPS_OFS_STOP       12'h014
`define SPS_C1_ENABLE      6
`define SPS_C1_MASTER      4
`define SPS_C1_IDLE        3
`define SPS_C1_PHASE       2
`define SPS_C1_SELOE       1
`define SPS_C1_ORDER       0
`define SPS_C2_MFEN        4
`define SPS_C2_SHOE        3
`define SPS_C2_SWIRE       0
`define SPS_ST_RXFULL      7
`define SPS_ST_MFAULT      4
`define SPS_ST_TXEMPTY     5
`define SPS_CTRL1_RST      8'h04
`define SPS_CTRL2_RST      8'h00
`define SPS_RATE_RST       8'h00
`define SPS_BITS           4'h8
`endif

// ==== hdl/sps_pkg.sv ====
// Types shared by the serial port design
package sps_pkg;
	typedef enum logic [1:0] {SPS_IDLE, SPS_SHIFT, SPS_DONE} sps_state_t;
	// Pin pair (output and enable) for a two-way pin
	typedef struct packed {
		logic o;
		logic oe;
	} sps_pin_t;
	// Configuration decoded from the control registers
	typedef struct packed {
		logic en;
		logic master;
		logic idle;
		logic phase;
		logic seloe;
		logic lsb;
		logic mfen;
		logic shoe;
		logic swire;
	} sps_cfg_t;
endpackage

// ==== tb/sps_slave_model.sv ====
// Far-side serial device: a mode-0 slave that swaps one byte with the port
`timescale 1ns/1ps
`default_nettype none
module sps_slave_model (
	// Serial lines
	input  wire logic       sck,
	input  wire logic       mosi,
	output logic            miso,
	// Bench control
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output logic      [7:0] rx
);
	logic [7:0] sh_q;
	logic [3:0] n_q;
	initial n_q = 4'h8;
	// No select input, the model acts as always selected; after the frame the line shows the inverse
	assign miso = (n_q == 4'h8) ? ~sh_q[7] : sh_q[7];
	// Queue a byte and restart the bit count
	always @(posedge load) begin
		sh_q = tx;
		n_q = 4'h0;
	end
	// Sample on the leading edge, only on the master's clock
	always @(posedge sck) begin
		rx <= {rx[6:0], mosi};
		n_q <= n_q + 4'h1;
	end
	// Shift out on the trailing edge
	always @(negedge sck) sh_q <= {sh_q[6:0], 1'b0};
endmodule
`default_nettype wire

// ==== tb/sps_port_tb.sv ====
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`include "sps_params.svh"
module sps_port_tb;
	logic        clk_sys, resetn, hwrite, hreadyout, hresp, stop_req, deep_stop_wake, nt, rd_dp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [11:0] haddr;
	logic [31:0] hwdata, hrdata, rd;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, p_miso, p_load;
	logic [7:0]  p_tx, p_rx;
	wire         sck_w, mosi_w, miso_w, ss_w;
	int          err_total, check_count, seed, hi_n, hi_last;
	logic [31:0] exp_q[$];
	// Line levels: pull-down on the clock, pull-up on mosi and select, the peer's output on miso
	assign sck_w = sck_oe ? sck_o : 1'b0;
	assign mosi_w = mosi_oe ? mosi_o : 1'b1;
	assign miso_w = miso_oe ? miso_o : p_miso;
	assign ss_w = ss_n_oe ? ss_n_o : 1'b1;
	sps_port uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req),
		.deep_stop_wake(deep_stop_wake), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
	sps_slave_model peer (.sck(sck_w), .mosi(mosi_w), .miso(p_miso), .load(p_load),
		.tx(p_tx), .rx(p_rx));
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// Read watcher: pairs each noted read with the oldest expectation
	always @(posedge clk_sys) begin
		if (rd_dp && hreadyout) chk(hrdata, exp_q.pop_front());
		rd_dp <= htrans[1] && !hwrite && nt && hreadyout;
	end
	// Length of the last high pulse on the serial clock
	always @(posedge clk_sys) begin
		if (sck_oe && sck_o) hi_n <= hi_n + 1;
		else if (hi_n != 0) begin
			hi_last <= hi_n;
			hi_n <= 0;
		end
	end
	// One single-word transfer; n notes the expected read value e
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic n, input logic [7:0] e);
		@(posedge clk_sys);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		nt <= n;
		if (n) exp_q.push_back({24'h00_0000, e});
		repeat (2) begin
			@(posedge clk_sys);
			if (!hreadyout) begin
				err_total++;
				results();
			end
			rd = hrdata;
			htrans <= 2'b00;
			hwdata <= {24'h00_0000, d};
			nt <= 1'b0;
		end
		// Let the write edge settle before anyone looks at outputs
		#1;
	endtask
	task automatic wait_rx();
		int k;
		for (k = 0; k < 300; k++) begin
			bus(1'b0, `SPS_OFS_STATUS, 8'h00, 1'b0, 8'h00);
			if (rd[`SPS_ST_RXFULL] === 1'b1) break;
		end
		if (k == 300) begin
			err_total++;
			results();
		end
	endtask
	function automatic logic [7:0] rev(input logic [7:0] x);
		return {<<{x}};
	endfunction
	// Master exchange with the peer at a given rate and shift order
	task automatic xfer(input logic [7:0] c1, input logic [7:0] rate, input int half);
		logic [7:0] t;
		t = $random(seed);
		p_tx <= $random(seed);
		bus(1'b1, `SPS_OFS_RATE, rate, 1'b0, 8'h00);
		bus(1'b1, `SPS_OFS_CTRL1, c1, 1'b0, 8'h00);
		chk({sck_oe, mosi_oe, miso_oe, ss_n_oe}, 4'hC);
		@(posedge clk_sys) p_load <= 1'b1;
		@(posedge clk_sys) p_load <= 1'b0;
		bus(1'b1, `SPS_OFS_DATA, t, 1'b0, 8'h00);
		wait_rx();
		bus(1'b0, `SPS_OFS_DATA, 8'h00, 1'b1, c1[0] ? rev(p_tx) : p_tx);
		chk(p_rx, c1[0] ? rev(t) : t);
		chk(hi_last, half);
		chk(sck_o, 1'b0);
	endtask
	initial begin
		seed = 45;
		err_total = 0;
		check_count = 0;
		hi_n = 0;
		hi_last = 0;
		{resetn, hwrite, nt, rd_dp, stop_req, deep_stop_wake, p_load} = 7'h00;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 12'h000;
		hwdata = 32'h0000_0000;
		p_tx = 8'h00;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({sck_oe, mosi_oe, miso_oe, ss_n_oe}, 4'h0);
		bus(1'b0, `SPS_OFS_CTRL1, 8'h00, 1'b1, `SPS_CTRL1_RST);
		bus(1'b0, `SPS_OFS_RATE, 8'h00, 1'b1, `SPS_RATE_RST);
		bus(1'b0, `SPS_OFS_STATUS, 8'h00, 1'b1, 8'h20);
		bus(1'b0, 12'h020, 8'h00, 1'b1, 8'h00);
		xfer(8'h50, 8'h00, 1);
		xfer(8'h51, 8'h21, 6);
		xfer(8'h50, 8'h72, 32);
		// Select pin and single-wire routing in master mode
		bus(1'b1, `SPS_OFS_CTRL2, 8'h10, 1'b0, 8'h00);
		chk(ss_n_oe, 1'b0);
		bus(1'b1, `SPS_OFS_CTRL1, 8'h52, 1'b0, 8'h00);
		chk(ss_n_oe, 1'b1);
		bus(1'b1, `SPS_OFS_CTRL2, 8'h09, 1'b0, 8'h00);
		chk({mosi_oe, miso_oe, ss_n_oe}, 3'b100);
		bus(1'b1, `SPS_OFS_CTRL2, 8'h01, 1'b0, 8'h00);
		chk(mosi_oe, 1'b0);
		bus(1'b1, `SPS_OFS_CTRL1, 8'h58, 1'b0, 8'h00);
		chk(sck_o, 1'b1);
		// Deselected single-wire slave drives nothing
		bus(1'b1, `SPS_OFS_CTRL1, 8'h40, 1'b0, 8'h00);
		chk({sck_oe, mosi_oe, miso_oe}, 3'b000);
		// Light stop keeps registers and ignores writes
		stop_req <= 1'b1;
		bus(1'b1, `SPS_OFS_CTRL2, 8'h10, 1'b0, 8'h00);
		stop_req <= 1'b0;
		bus(1'b0, `SPS_OFS_CTRL2, 8'h00, 1'b1, 8'h01);
		bus(1'b1, `SPS_OFS_CTRL1, 8'h00, 1'b0, 8'h00);
		chk({sck_oe, mosi_oe, miso_oe, ss_n_oe}, 4'h0);
		bus(1'b0, `SPS_OFS_STATUS, 8'h00, 1'b1, 8'h20);
		@(posedge clk_sys) deep_stop_wake <= 1'b1;
		@(posedge clk_sys) deep_stop_wake <= 1'b0;
		bus(1'b0, `SPS_OFS_CTRL2, 8'h00, 1'b1, `SPS_CTRL2_RST);
		repeat (2) @(posedge clk_sys);
		results();
	end
endmodule
`default_nettype wire
